//--- bench/sstl_chk_asserts.sv
// Purpose: port assertions for the traffic loopback
// Assumes: one clock, synchronous reset
// Notes:   pin inputs act two edges late
`timescale 1ns/1ps
`default_nettype none
module sstl_chk (
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  input wire logic                 cmd_valid,
  input wire sstl_pkg::sstl_cmd_t  cmd,
  input wire logic                 tch_active,
  input wire logic                 power_off,
  input wire logic                 card_removed,
  input wire logic                 frame_tick,
  input wire logic                 ul_valid,
  input wire sstl_pkg::sstl_ul_t   ul_word,
  input wire logic                 ul_ready,
  input wire logic                 close_ack,
  input wire logic                 loop_closed,
  input wire sstl_pkg::sstl_loop_t loop_sel,
  input wire logic [2:0]           loop_tch,
  input wire logic                 dai_enable,
  input wire logic                 loop_c_run,
  input wire logic                 own_midamble
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // pins quiet, then a close command that must be taken
  sequence s_quiet;
    !power_off && !card_removed;
  endsequence
  sequence s_close;
    cmd_valid && cmd.close && !cmd.open && cmd.on_dcch && cmd.acked &&
    cmd.sapi == sstl_pkg::SAPI_TEST && tch_active && !loop_closed &&
    !dai_enable;
  endsequence
  AST_CLOSE: assert property (
    s_quiet[*3] ##0 s_close |=> close_ack && loop_closed &&
    loop_tch == $past(cmd.tch) && loop_sel == $past(cmd.loop))
    else $error("close not taken");
  AST_REFUSE: assert property (
    cmd_valid && (loop_closed || !tch_active) |=> !close_ack)
    else $error("refused close acknowledged");
  AST_PULSE: assert property (
    close_ack |=> !close_ack) else $error("ack longer than a cycle");
  AST_SAPI: assert property (
    close_ack |-> $past(cmd_valid) && $past(cmd.on_dcch) &&
    $past(cmd.sapi) == sstl_pkg::SAPI_TEST) else $error("ack on bad path");
  AST_FLAG: assert property (
    $rose(loop_closed) |-> close_ack) else $error("closed without ack");
  AST_EXCL: assert property (
    !(loop_closed && dai_enable)) else $error("loop and audio test both on");
  AST_END: assert property (
    (power_off || card_removed)[*5] |-> !loop_closed && !loop_c_run)
    else $error("test survives pin ending");
  AST_MID: assert property (
    own_midamble == (loop_c_run && loop_sel == sstl_pkg::LOOP_C))
    else $error("midamble select wrong");
  AST_CRUN: assert property (
    $rose(loop_c_run) |-> loop_closed && $past(frame_tick) &&
    loop_sel == sstl_pkg::LOOP_C) else $error("burst loop start wrong");
  AST_HOLD: assert property (
    ul_valid && !ul_ready |=> ul_valid && $stable(ul_word))
    else $error("uplink word not held");
  AST_NBITS: assert property (
    ul_valid && ul_word.last |->
    ul_word.nbits == (ul_word.burst ? 5'h02 : 5'h04))
    else $error("closing word size wrong");
endmodule
bind sstl_loop_top sstl_chk chk_u (.clk_sys, .sys_rst, .cmd_valid, .cmd,
  .tch_active, .power_off, .card_removed, .frame_tick, .ul_valid, .ul_word,
  .ul_ready, .close_ack, .loop_closed, .loop_sel, .loop_tch, .dai_enable,
  .loop_c_run, .own_midamble);
`default_nettype wire

//--- bench/sstl_ss_model.sv
// Purpose: uplink receiver of the test equipment
// Assumes: a word moves on ul_valid and ul_ready
// Notes:   slow mode stalls two cycles in three
`timescale 1ns/1ps
`default_nettype none
module sstl_ss_model (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic slow,
  input  wire logic ul_valid,
  output var logic  ul_ready
);
  // ready moves just after each edge
  initial ul_ready = 1'b0;
  always @(posedge clk_sys) begin
    ul_ready <= #1 !sys_rst && (!slow || $urandom_range(2) == 0);
  end
endmodule
`default_nettype wire

//--- bench/tb_single_slot_traffic_loopback.sv
// Purpose: self-checking bench for the traffic loopback
// Assumes: design files compiled first
// Notes:   expected uplink words queue up as stimulus is sent
`timescale 1ns/1ps
`default_nettype none
module tb_single_slot_traffic_loopback;
  logic                  clk_sys, sys_rst, cmd_valid, tch_active, dai_req;
  logic                  power_off, card_removed, frame_tick, fn_sync, slow;
  logic                  dec_valid, dec_ready, brx_valid, brx_ready;
  logic                  ul_valid, ul_ready, close_ack, loop_closed;
  logic                  dai_enable, loop_c_run, own_midamble, ul_ctrl_frame;
  logic [2:0]            loop_tch;
  sstl_pkg::sstl_cmd_t   cmd;
  sstl_pkg::sstl_dec_t   dec_word;
  sstl_pkg::sstl_burst_t brx_word;
  sstl_pkg::sstl_ul_t    ul_word;
  sstl_pkg::sstl_loop_t  loop_sel;
  sstl_pkg::sstl_ul_t    exp_q[$];
  int                    err_total, check_count;
  int                    md = -1;

  sstl_loop_top #(.RTD_FRAMES(1), .FIFO_DEPTH(8)) dut_u (
    .clk_sys, .sys_rst, .cmd_valid, .cmd, .tch_active, .dai_req, .power_off,
    .card_removed, .frame_tick, .fn_sync, .dec_valid, .dec_word, .dec_ready,
    .brx_valid, .brx_word, .brx_ready, .ul_valid, .ul_word, .ul_ready,
    .close_ack, .loop_closed, .loop_sel, .loop_tch, .dai_enable, .loop_c_run,
    .own_midamble, .ul_ctrl_frame);
  sstl_ss_model ss_u (.clk_sys, .sys_rst, .slow, .ul_valid, .ul_ready);

  // 200 MHz system clock
  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  // count a comparison, report a mismatch
  task automatic chk(input logic ok, input string what);
    check_count++;
    if (!ok) begin
      err_total++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  // one decoded command: close, or open when cl is low
  task automatic command(input logic cl, input logic [1:0] lp,
                         input logic [2:0] ch, sp);
    @(posedge clk_sys);
    #1 cmd_valid = 1'b1;
    cmd = '{cl, !cl, sstl_pkg::sstl_loop_t'(lp), ch, 1'b1, sp, 1'b1};
    @(posedge clk_sys);
    #1 cmd_valid = 1'b0;
  endtask

  // one decoded frame, expected back in loops A and B
  task automatic frame(input logic [1:0] rt, input logic bfi, input logic fa);
    int          n;
    logic [15:0] d;
    n = (rt == 2'h2) ? 16 : 17;
    dec_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      d = 16'($urandom);
      dec_word = '{d, i == 0, bfi, fa, sstl_pkg::sstl_rate_t'(rt)};
      do @(posedge clk_sys); while (dec_ready !== 1'b1);
      if (md >= 0 && md < 2 && !fa)
        exp_q.push_back('{(bfi && md == 0) ? 16'h0 : d, i == n - 1,
                          (i == n - 1) ? 5'h04 : 5'h10, 1'b0});
      #1;
    end
  endtask

  // one 8-word burst; control bursts are not expected back
  task automatic burst(input logic ctl);
    logic [15:0] d;
    brx_valid = 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      brx_word = '{d, i == 0, ctl};
      do @(posedge clk_sys); while (brx_ready !== 1'b1);
      if (!ctl) exp_q.push_back('{d, i == 7, (i == 7) ? 5'h02 : 5'h10, 1'b1});
      #1;
    end
  endtask

  // frame start pulse, then a few quiet cycles
  task automatic tick();
    frame_tick = 1'b1;
    @(posedge clk_sys);
    #1 frame_tick = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // drop valids, then wait, bounded, for every expected word
  task automatic drain();
    {dec_valid, brx_valid} = 2'h0;
    for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge clk_sys);
    chk(exp_q.size() == 0, "uplink words missing");
    #1;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // uplink scoreboard against the model queue
  always @(posedge clk_sys) begin
    if (ul_valid === 1'b1 && ul_ready === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected uplink word");
      else chk(ul_word === exp_q.pop_front(), "uplink word");
    end
  end

  // watchdog: the run needs under 1,000 cycles
  initial begin
    #300000;
    err_total++;
    results();
  end

  // main sequence
  initial begin
    {cmd_valid, tch_active, dai_req, power_off, card_removed, frame_tick,
     fn_sync, dec_valid, brx_valid, slow, cmd, dec_word, brx_word} = '0;
    sys_rst = 1'b1;
    void'($urandom(49));
    repeat (2) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    command(1'b1, 2'h0, 3'h5, 3'h0);
    chk(close_ack === 1'b0, "ack without channel");
    tch_active = 1'b1;
    command(1'b1, 2'h0, 3'h5, 3'h1);
    chk(close_ack === 1'b0, "ack on wrong link point");
    dai_req = 1'b1;
    command(1'b1, 2'h0, 3'h5, 3'h0);
    chk(dai_enable === 1'b1 && close_ack === 1'b0, "audio test");
    dai_req = 1'b0;
    for (int lp = 0; lp < 3; lp++) begin
      command(1'b1, 2'(lp), 3'(lp + 4), 3'h0);
      chk(close_ack === 1'b1 && loop_tch === 3'(lp + 4), "close ack");
      chk(loop_sel === sstl_pkg::sstl_loop_t'(lp), "loop type");
      md = lp;
      dai_req = 1'b1;
      command(1'b1, 2'h0, 3'h1, 3'h0);
      chk(close_ack === 1'b0 && loop_closed === 1'b1, "reclose");
      chk(dai_enable === 1'b0, "audio test while looped");
      dai_req = 1'b0;
      if (lp < 2) begin
        slow = 1'(lp);
        for (int r = 0; r < 3; r++) frame(2'(r), 1'b0, 1'b0);
        frame(2'h0, 1'b1, 1'b0);
        if (lp == 0) frame(2'h1, 1'b0, 1'b1);
        drain();
      end else begin
        fn_sync = 1'b1;
        @(posedge clk_sys);
        #1 fn_sync = 1'b0;
        tick();
        chk(loop_c_run === 1'b1, "burst loop idle");
        burst(1'b1);
        burst(1'b0);
        repeat (10) @(posedge clk_sys);
        #1 chk(ul_valid === 1'b0, "burst sent early");
        tick();
        drain();
        slow = 1'b1;
        fork
          repeat (2) burst(1'b0);
          begin
            repeat (40) @(posedge clk_sys);
            #1 chk(brx_ready === 1'b0, "buffer overfilled");
            tick();
            repeat (100) @(posedge clk_sys);
            #1 tick();
          end
        join
        drain();
        slow = 1'b0;
        repeat (7) tick();
        chk(ul_ctrl_frame === 1'b0, "control frame early");
        tick();
        chk(ul_ctrl_frame === 1'b1, "control frame missing");
      end
      command(1'b0, 2'h0, 3'h0, 3'h0);
      chk(loop_closed === 1'b0, "loop still closed");
      md = -1;
    end
    for (int p = 0; p < 2; p++) begin
      command(1'b1, 2'h2, 3'h3, 3'h0);
      {power_off, card_removed} = 2'(p + 1);
      repeat (5) @(posedge clk_sys);
      #1 chk(loop_closed === 1'b0, "test not ended");
      {power_off, card_removed} = 2'h0;
      repeat (5) @(posedge clk_sys);
    end
    results();
  end
endmodule
`default_nettype wire

//--- design/sstl_fifo.sv
// Purpose: word buffer in the loopback data path
// Assumes: one clock, synchronous clear
// Notes:   depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module sstl_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         clr,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("fifo depth must be a power of two");
    end
  endgenerate

  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  wire           push;
  wire           pop;

  // flags from the fill count
  assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk_sys) begin
    if (sys_rst || clr) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_reg + AW'(push);
      rd_reg  <= rd_reg + AW'(pop);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- design/sstl_loop_top.sv
// Purpose: single-slot traffic loopback, loops A, B and C
// Assumes: decoder, demodulator and encoder on clk_sys
// Notes:   power-off and card-removal pins are synchronised here
`timescale 1ns/1ps
`default_nettype none
module sstl_loop_top #(
  parameter int RTD_FRAMES = sstl_pkg::RTD_DEF,
  parameter int FIFO_DEPTH = sstl_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic                 cmd_valid,
  input  wire sstl_pkg::sstl_cmd_t  cmd,
  input  wire logic                 tch_active,
  input  wire logic                 dai_req,
  input  wire logic                 power_off,
  input  wire logic                 card_removed,
  input  wire logic                 frame_tick,
  input  wire logic                 fn_sync,
  input  wire logic                 dec_valid,
  input  wire sstl_pkg::sstl_dec_t  dec_word,
  output logic                      dec_ready,
  input  wire logic                 brx_valid,
  input  wire sstl_pkg::sstl_burst_t brx_word,
  output logic                      brx_ready,
  output logic                      ul_valid,
  output sstl_pkg::sstl_ul_t        ul_word,
  input  wire logic                 ul_ready,
  output logic                      close_ack,
  output logic                      loop_closed,
  output sstl_pkg::sstl_loop_t      loop_sel,
  output logic [2:0]                loop_tch,
  output logic                      dai_enable,
  output logic                      loop_c_run,
  output logic                      own_midamble,
  output logic                      ul_ctrl_frame
);
  localparam int NW = sstl_pkg::WORD_W;
  localparam int UW = $bits(sstl_pkg::sstl_ul_t);
  localparam logic [4:0] BURST_WORDS =
    sstl_pkg::words_of(sstl_pkg::BURST_BITS);

  // ------------------------
  // parameter checks
  // ------------------------
  generate
    if (RTD_FRAMES < 1 || RTD_FRAMES >= sstl_pkg::RTD_LIMIT) begin : g_rtd
      $error("round trip delay out of range");
    end
    if (sstl_pkg::SETUP_FRAMES > sstl_pkg::REPORT_FRAMES) begin : g_set
      $error("loop setup slower than one reporting period");
    end
    if (FIFO_DEPTH < int'(BURST_WORDS)) begin : g_dep
      $error("buffer cannot hold one burst");
    end
  endgenerate

  typedef enum logic [2:0] {
    S_WAIT = 3'b001,
    S_PASS = 3'b010,
    S_SKIP = 3'b100
  } sstl_st_t;

  // ------------------------
  // declarations
  // ------------------------
  logic [1:0]           off_meta_reg;
  logic [1:0]           off_sync_reg;
  logic                 closed_reg;
  logic                 closed_next;
  logic                 dai_en_reg;
  logic                 dai_en_next;
  logic                 ack_reg;
  logic                 c_run_reg;
  logic                 c_run_next;
  logic                 mid_reg;
  sstl_pkg::sstl_loop_t sel_reg;
  logic [2:0]           tch_reg;
  sstl_st_t             st_reg;
  sstl_st_t             st_next;
  logic [4:0]           idx_reg;
  logic [4:0]           lenw_reg;
  logic [4:0]           tail_reg;
  logic                 zero_reg;
  logic [4:0]           send_cnt_reg;
  logic                 ul_valid_reg;
  sstl_pkg::sstl_ul_t   ul_word_reg;
  logic                 send_go;
  logic                 ctrl_frame;
  logic                 f_in_ready;
  logic                 f_out_valid;
  logic [UW-1:0]        f_out_data;

  wire                  stop_pin;
  wire                  path_ok;
  wire                  close_ok;
  wire                  open_ok;
  wire                  end_all;
  wire                  is_a;
  wire                  is_c;
  wire                  path_on;
  wire                  in_valid;
  wire                  in_first;
  wire [NW-1:0]         in_data;
  wire                  keep_fr;
  wire                  zero_new;
  wire [4:0]            lenw_new;
  wire [4:0]            tail_new;
  wire [4:0]            cur_idx;
  wire [4:0]            cur_len;
  wire [4:0]            cur_tail;
  wire                  cur_zero;
  wire                  is_last;
  wire                  want;
  wire                  push;
  wire                  drop_start;
  wire                  capture;
  wire                  in_rdy_eff;
  wire                  gate;
  wire                  pop;
  sstl_pkg::sstl_ul_t   push_word;

  // ------------------------
  // pin synchronisers, power-off and card removal
  // ------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      off_meta_reg <= 2'h0;
      off_sync_reg <= 2'h0;
    end else begin
      off_meta_reg <= {card_removed, power_off};
      off_sync_reg <= off_meta_reg;
    end
  end

  // ------------------------
  // command handling
  // ------------------------
  // only dedicated channel, link point zero, acknowledged mode
  assign path_ok  = cmd.on_dcch & cmd.acked &
                    (cmd.sapi == sstl_pkg::SAPI_TEST);
  assign stop_pin = |off_sync_reg;
  assign open_ok  = cmd_valid & cmd.open & path_ok;
  assign end_all  = open_ok | stop_pin;
  // audio test counts as a running test function
  assign close_ok = cmd_valid & cmd.close & path_ok & tch_active &
                    ~closed_reg & ~dai_en_reg & ~end_all;
  assign closed_next = end_all  ? 1'b0 :
                       close_ok ? 1'b1 : closed_reg;
  assign dai_en_next = dai_req & ~stop_pin & ~closed_next;
  // burst loop starts at the first frame after closing
  assign c_run_next  = end_all ? 1'b0 :
                       (closed_reg & is_c & frame_tick) ? 1'b1 :
                       c_run_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      closed_reg <= 1'b0;
      dai_en_reg <= 1'b0;
      ack_reg    <= 1'b0;
      c_run_reg  <= 1'b0;
      mid_reg    <= 1'b0;
    end else begin
      closed_reg <= closed_next;
      dai_en_reg <= dai_en_next;
      ack_reg    <= close_ok;
      c_run_reg  <= c_run_next;
      mid_reg    <= c_run_next;
    end
  end

  // loop type and channel taken as decoded fields
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sel_reg <= sstl_pkg::LOOP_A;
      tch_reg <= 3'h0;
    end else if (close_ok) begin
      sel_reg <= cmd.loop;
      tch_reg <= cmd.tch;
    end
  end

  // ------------------------
  // source selection and frame shaping
  // ------------------------
  assign is_a     = sel_reg == sstl_pkg::LOOP_A;
  assign is_c     = sel_reg == sstl_pkg::LOOP_C;
  assign path_on  = is_c ? c_run_reg : closed_reg;
  assign in_valid = is_c ? brx_valid : dec_valid;
  assign in_first = is_c ? brx_word.first : dec_word.first;
  assign in_data  = is_c ? brx_word.data : dec_word.data;
  // control bursts and FACCH frames are not looped
  assign keep_fr  = is_c ? ~brx_word.ctrl : ~dec_word.facch;
  // bad frames zeroed in loop A only, loop B passes all
  assign zero_new = is_a & dec_word.bfi;
  assign lenw_new =
    is_c ? BURST_WORDS :
    (dec_word.rate == sstl_pkg::RATE_EFR) ?
      sstl_pkg::words_of(sstl_pkg::FR_BITS_EFR) :
      sstl_pkg::words_of(sstl_pkg::FR_BITS_FULL);
  assign tail_new =
    is_c ? sstl_pkg::tail_of(sstl_pkg::BURST_BITS) :
    (dec_word.rate == sstl_pkg::RATE_EFR) ?
      sstl_pkg::tail_of(sstl_pkg::FR_BITS_EFR) :
      sstl_pkg::tail_of(sstl_pkg::FR_BITS_FULL);

  // per-word context, fresh on a first word
  assign cur_idx  = in_first ? 5'h00 : idx_reg;
  assign cur_len  = in_first ? lenw_new : lenw_reg;
  assign cur_tail = in_first ? tail_new : tail_reg;
  assign cur_zero = in_first ? zero_new : zero_reg;
  assign is_last  = cur_idx == (cur_len - 5'h01);
  assign want     = path_on & in_valid &
                    (in_first ? keep_fr : (st_reg == S_PASS));
  assign push       = want & f_in_ready;
  assign drop_start = path_on & in_valid & in_first & ~keep_fr;
  assign capture    = push & is_last & is_c;
  assign in_rdy_eff = ~want | f_in_ready;
  assign dec_ready  = is_c ? 1'b1 : in_rdy_eff;
  assign brx_ready  = is_c ? in_rdy_eff : 1'b1;

  assign push_word.data  = cur_zero ? '0 : in_data;
  assign push_word.last  = is_last;
  assign push_word.nbits = is_last ? cur_tail : 5'(NW);
  assign push_word.burst = is_c;

  // frame walker next state
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      S_WAIT, S_PASS, S_SKIP: begin
        if (push) begin
          st_next = is_last ? S_SKIP : S_PASS;
        end else if (drop_start) begin
          st_next = S_SKIP;
        end
      end
      default: st_next = S_WAIT;
    endcase
    if (end_all || !path_on) begin
      st_next = S_WAIT;
    end
  end

  // frame walker registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg   <= S_WAIT;
      idx_reg  <= 5'h00;
      lenw_reg <= 5'h00;
      tail_reg <= 5'h00;
      zero_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (push) begin
        idx_reg  <= cur_idx + 5'h01;
        lenw_reg <= cur_len;
        tail_reg <= cur_tail;
        zero_reg <= cur_zero;
      end
    end
  end

  // ------------------------
  // buffer and burst release timing
  // ------------------------
  sstl_fifo #(
    .W     (UW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clr       (end_all),
    .in_valid  (push),
    .in_data   (push_word),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (pop)
  );

  sstl_sched #(
    .RTD (RTD_FRAMES)
  ) u_sched (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .clr        (end_all),
    .frame_tick (frame_tick),
    .fn_sync    (fn_sync),
    .capture    (capture),
    .send_go    (send_go),
    .ctrl_frame (ctrl_frame)
  );

  // ------------------------
  // uplink output stage
  // ------------------------
  // bursts leave only in their release frame
  assign gate = ~is_c | (send_cnt_reg != 5'h00);
  assign pop  = f_out_valid & gate & (~ul_valid_reg | ul_ready);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || end_all) begin
      send_cnt_reg <= 5'h00;
    end else if (send_go) begin
      send_cnt_reg <= BURST_WORDS;
    end else if (pop && is_c) begin
      send_cnt_reg <= send_cnt_reg - 5'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ul_valid_reg <= 1'b0;
      ul_word_reg  <= '0;
    end else if (pop) begin
      ul_valid_reg <= 1'b1;
      ul_word_reg  <= f_out_data;
    end else if (ul_ready) begin
      ul_valid_reg <= 1'b0;
    end
  end

  // output drive
  assign ul_valid      = ul_valid_reg;
  assign ul_word       = ul_word_reg;
  assign close_ack     = ack_reg;
  assign loop_closed   = closed_reg;
  assign loop_sel      = sel_reg;
  assign loop_tch      = tch_reg;
  assign dai_enable    = dai_en_reg;
  assign loop_c_run    = c_run_reg;
  assign own_midamble  = mid_reg;
  assign ul_ctrl_frame = ctrl_frame;
endmodule
`default_nettype wire

//--- design/sstl_pkg.sv
// Purpose: constants and types of the single-slot traffic loopback
// Assumes: frames and bursts arrive as 16-bit words, first word flagged
// Notes:   one TDMA frame tick per frame from the timing unit
// Function
// - ignore close command without active traffic channel or with a loop closed
// - with traffic channel active, close loop on named channel and acknowledge
// - loop A feeds good decoded frames back to the encoder, same channel
// - full-rate and half-rate speech loops 260 decoded bits
// - enhanced full-rate speech loops 244 bits
// - loop A replaces a bad speech frame by an all-zero frame
// - loop A leaves uplink undefined for FACCH frames; FACCH works normally
// - loop B returns every speech frame with no erased-frame signalling
// - loop C sends the 114 burst bits taken after decryption
// - loop C repeats every traffic burst and uses its own midamble
// - loop C never loops control or idle bursts
// - loop C runs within 104 frames after the acknowledgement
// - loop C round trip below 26 frames, fixed and declared
// - uplink control frame keeps its place; later bursts slip one frame
// - traffic loops and audio interface test never active together
// - commands come on dedicated control channel, link point 0, acknowledged
// - power-off or card removal ends every test function
package sstl_pkg;

  // ------------------------
  // sizes and timing
  // ------------------------
  localparam int WORD_W        = 16;
  localparam int FR_BITS_FULL  = 260;
  localparam int FR_BITS_EFR   = 244;
  localparam int BURST_BITS    = 114;
  localparam int MF_LEN        = 26;
  localparam int MF_CTRL_POS   = 12;
  localparam int MF_IDLE_POS   = 25;
  localparam int RTD_LIMIT     = 26;
  localparam int RTD_DEF       = 1;
  localparam int REPORT_FRAMES = 104;
  localparam int SETUP_FRAMES  = 1;
  localparam int FIFO_DEPTH_DEF = 8;
  localparam logic [2:0] SAPI_TEST = 3'h0;

  // ------------------------
  // enumerations and carriers
  // ------------------------
  typedef enum logic [1:0] {
    LOOP_A = 2'h0,
    LOOP_B = 2'h1,
    LOOP_C = 2'h2
  } sstl_loop_t;

  typedef enum logic [1:0] {
    RATE_FULL = 2'h0,
    RATE_HALF = 2'h1,
    RATE_EFR  = 2'h2
  } sstl_rate_t;

  typedef struct packed {
    logic       close;
    logic       open;
    sstl_loop_t loop;
    logic [2:0] tch;
    logic       on_dcch;
    logic [2:0] sapi;
    logic       acked;
  } sstl_cmd_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic              first;
    logic              bfi;
    logic              facch;
    sstl_rate_t        rate;
  } sstl_dec_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic              first;
    logic              ctrl;
  } sstl_burst_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic              last;
    logic [4:0]        nbits;
    logic              burst;
  } sstl_ul_t;

  // words needed for a bit count
  function automatic logic [4:0] words_of(input int bits);
    words_of = 5'((bits + WORD_W - 1) / WORD_W);
  endfunction

  // valid bits in the closing word
  function automatic logic [4:0] tail_of(input int bits);
    tail_of = 5'(bits - (int'(words_of(bits)) - 1) * WORD_W);
  endfunction

endpackage

//--- design/sstl_sched.sv
// Purpose: burst release timing for the burst-by-burst loop
// Assumes: frame_tick marks the start of each TDMA frame
// Notes:   fn_sync realigns the multiframe count to zero
`timescale 1ns/1ps
`default_nettype none
module sstl_sched #(
  parameter int RTD = 1
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic clr,
  input  wire logic frame_tick,
  input  wire logic fn_sync,
  input  wire logic capture,
  output logic      send_go,
  output logic      ctrl_frame
);
  logic [4:0]   fn_reg;
  logic [4:0]   fn_next;
  logic         cap_reg;
  logic [RTD:0] line_reg;
  logic [3:0]   pend_reg;
  wire  [RTD+1:0] line_sh;
  wire  [3:0]   avail;
  wire          due;
  wire          ctrl_new;
  wire          go;

  // multiframe position of the frame now starting
  assign fn_next  = fn_sync ? 5'h00 :
                    (fn_reg == 5'(sstl_pkg::MF_LEN - 1)) ? 5'h00 :
                    fn_reg + 5'h01;
  assign ctrl_new = fn_next == 5'(sstl_pkg::MF_CTRL_POS) ||
                    fn_next == 5'(sstl_pkg::MF_IDLE_POS);
  // fixed delay line, one bit per frame
  assign line_sh  = {line_reg, cap_reg | capture};
  assign due      = frame_tick & line_sh[RTD-1];
  assign avail    = pend_reg + 4'(due);
  // control frame holds its place, burst waits a frame
  assign go       = frame_tick & (avail != 4'h0) & ~ctrl_new;

  // frame count and release bookkeeping
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fn_reg <= 5'h00;
    end else if (frame_tick || fn_sync) begin
      fn_reg <= fn_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || clr) begin
      cap_reg    <= 1'b0;
      line_reg   <= '0;
      pend_reg   <= 4'h0;
      send_go    <= 1'b0;
      ctrl_frame <= 1'b0;
    end else begin
      cap_reg    <= frame_tick ? 1'b0 : (cap_reg | capture);
      line_reg   <= frame_tick ? line_sh[RTD:0] : line_reg;
      pend_reg   <= avail - 4'(go);
      send_go    <= go;
      ctrl_frame <= frame_tick ? ctrl_new : ctrl_frame;
    end
  end
endmodule
`default_nettype wire
